// ===== src/drum_step_sequencer.sv
`timescale 1ns/100ps

// Overview of operation
// - pattern length programmable up to 64 steps
// - four zones of 16 steps map pads
// - step through length, wrap, repeat forever
// - step rate from tempo and resolution
// - zone select cycles only covered zones
// - program mode sends on channel, reset 16
// - program mode output needs enable, default off
// - never send or act on program change
// - combi timbre 16 sequenced when select set
// - combi sends only for ext or ext2 routing
// - song track 16 sequenced when select set
// - song sends for both, ext or ext2
// - run during count-in waits for recording
// - run press toggles; run state not stored
// - pad press inverts step; on steps sound
// - held edit: pads pick tone or accent
// - favourites edits allowed but never saved
// - align steps to playing arpeggiator
// - song mode aligns to drum track
// - song playback aligns at beat granularity
// - song start or Start resets position
// - follow external clock and Start when selected
// - thirteen tones, tone 13 is accent
module drum_step_sequencer #(
	parameter int AUTO_TIMEOUT_CYCLES = drum_seq_pkg::AUTO_TIMEOUT_CYC
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// midi realtime pins (asynchronous)
	input wire logic MIDI_CLK_TICK,
	input wire logic MIDI_START,
	// front panel, one-cycle presses
	input wire logic RUN_PRESS,
	input wire logic ZONE_PRESS,
	input wire logic PAD_PRESS,
	input wire logic [3:0] PAD_NUM,
	input wire logic EDIT_HOLD,
	input wire logic PAD_EDIT_ACTIVE,
	input wire logic FAV_PLAY,
	// companion blocks
	input wire logic ARP_PLAYING,
	input wire logic ARP_STEP,
	input wire logic DRUM_PLAYING,
	input wire logic DRUM_STEP,
	input wire logic SONG_PLAYING,
	input wire logic SONG_BEAT,
	input wire logic SONG_START,
	input wire logic REC_COUNT_IN,
	input wire logic REC_START,
	// step stream
	output logic STEP_STROBE,
	output logic [11:0] STEP_HITS,
	output logic STEP_ACCENT,
	output logic [5:0] STEP_POS,
	output logic NOTE_TX_EN,
	output logic [3:0] NOTE_CHANNEL,
	output logic SEQ_DRIVE,
	output logic RUNNING,
	output logic [1:0] ZONE_SEL,
	output logic [3:0] TONE_SEL
);
	import drum_seq_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [5:0] len_m1;
		logic [1:0] res;
		logic [1:0] spb;
		mode_e mode;
		src_e src;
		logic out_en;
		logic seq_sel;
		route_e route;
		logic [3:0] prog_chan;
		logic [3:0] part_chan;
		logic [23:0] tick_period;
		logic [3:0] pat_sel;
		logic [NUM_TONES-1:0][63:0] pattern;
		run_e run;
		logic [5:0] pos;
		logic [23:0] tick_div;
		logic [4:0] tick_cnt;
		logic [1:0] zone;
		logic [3:0] tone;
		logic dirty;
		logic [22:0] seen_cnt;
		logic mclk_s1;
		logic mclk_s2;
		logic mclk_s3;
		logic mstart_s1;
		logic mstart_s2;
		logic mstart_s3;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic strobe;
		logic [11:0] hits;
		logic accent;
		logic tx_en;
		logic [3:0] chan;
		logic drive;
		logic running;
	} state_s;

	state_s s_r;
	state_s s_nxt;
	logic [NUM_TONES-1:0] col;

	// current step column of every tone
	genvar g;
	generate
		for (g = 0; g < NUM_TONES; g++) begin : g_col
			assign col[g] = s_r.pattern[g][s_r.pos];
		end
	endgenerate

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic ext_follow;
		logic ext_tick;
		logic ext_start;
		logic int_tick;
		logic tick;
		logic align;
		logic restart;
		logic boundary;
		logic setup;
		logic wr;
		logic [4:0] res_ticks;
		logic [4:0] tps;
		logic [31:0] rd;
		logic [1:0] last_zone;
		ext_follow = 1'b0;
		ext_tick = 1'b0;
		ext_start = 1'b0;
		int_tick = 1'b0;
		tick = 1'b0;
		align = 1'b0;
		restart = 1'b0;
		boundary = 1'b0;
		setup = 1'b0;
		wr = 1'b0;
		res_ticks = TICKS_PER_QUARTER;
		tps = TICKS_PER_QUARTER;
		rd = 32'h0000_0000;
		last_zone = s_r.len_m1[5:4];
		s_nxt = s_r;

		// midi pins: two-flop sync, edges taken past the second flop
		s_nxt.mclk_s1 = MIDI_CLK_TICK;
		s_nxt.mclk_s2 = s_r.mclk_s1;
		s_nxt.mclk_s3 = s_r.mclk_s2;
		s_nxt.mstart_s1 = MIDI_START;
		s_nxt.mstart_s2 = s_r.mstart_s1;
		s_nxt.mstart_s3 = s_r.mstart_s2;
		ext_tick = s_r.mclk_s2 & ~s_r.mclk_s3;
		ext_start = s_r.mstart_s2 & ~s_r.mstart_s3;

		// auto source: clock counts as present until timeout
		if (ext_tick) begin
			s_nxt.seen_cnt = 23'(AUTO_TIMEOUT_CYCLES);
		end else if (s_r.seen_cnt != 23'h000000) begin
			s_nxt.seen_cnt = s_r.seen_cnt - 23'h000001;
		end
		ext_follow = (s_r.src == SRC_CLOCK_A) || (s_r.src == SRC_EXT_USB_CLOCK) ||
			((s_r.src == SRC_AUTO) && (s_r.seen_cnt != 23'h000000));

		// internal 24-per-quarter tick from tempo period
		if (s_r.tick_div >= s_r.tick_period - 24'h000001) begin
			s_nxt.tick_div = 24'h000000;
			int_tick = 1'b1;
		end else begin
			s_nxt.tick_div = s_r.tick_div + 24'h000001;
		end
		tick = ext_follow ? ext_tick : int_tick;

		// ticks per step from resolution and steps per beat
		unique case (s_r.res)
			2'h0: res_ticks = TICKS_PER_QUARTER;
			2'h1: res_ticks = TICKS_PER_QUARTER >> 1;
			2'h2: res_ticks = TICKS_PER_QUARTER >> 2;
			2'h3: res_ticks = TICKS_PER_QUARTER >> 3;
		endcase
		tps = res_ticks >> ((s_r.spb == 2'h3) ? 2'h2 : s_r.spb);
		if (tps == 5'h00) begin
			tps = 5'h01;
		end

		// phase alignment to companion players
		align = (ARP_PLAYING & ARP_STEP) |
			((s_r.mode == MODE_SONG) & DRUM_PLAYING & DRUM_STEP) |
			((s_r.mode == MODE_SONG) & SONG_PLAYING & SONG_BEAT);
		restart = SONG_START | (ext_follow & ext_start);

		// run control
		unique case (s_r.run)
			RUN_STOP: begin
				if (RUN_PRESS) begin
					if (REC_COUNT_IN) begin
						s_nxt.run = RUN_WAIT;
					end else begin
						s_nxt.run = RUN_PLAY;
						restart = 1'b1;
					end
				end
			end
			RUN_WAIT: begin
				if (RUN_PRESS) begin
					s_nxt.run = RUN_STOP;
				end else if (REC_START) begin
					s_nxt.run = RUN_PLAY;
					restart = 1'b1;
				end
			end
			RUN_PLAY: begin
				if (RUN_PRESS) begin
					s_nxt.run = RUN_STOP;
				end
			end
			default: s_nxt.run = RUN_STOP;
		endcase

		// step advance and wrap
		s_nxt.strobe = 1'b0;
		if (s_r.run == RUN_PLAY) begin
			boundary = align | (tick & (s_r.tick_cnt >= tps - 5'h01));
			if (boundary) begin
				s_nxt.tick_cnt = 5'h00;
			end else if (tick) begin
				s_nxt.tick_cnt = s_r.tick_cnt + 5'h01;
			end
			if (align) begin
				s_nxt.tick_div = 24'h000000;
			end
		end
		if (boundary) begin
			s_nxt.strobe = 1'b1;
			s_nxt.hits = s_nxt.drive ? col[NUM_INST_TONES-1:0] : 12'h000;
			s_nxt.accent = s_nxt.drive & col[ACCENT_TONE];
			if (s_r.pos >= s_r.len_m1) begin
				s_nxt.pos = 6'h00;
			end else begin
				s_nxt.pos = s_r.pos + 6'h01;
			end
		end
		if (restart) begin
			s_nxt.pos = 6'h00;
			s_nxt.tick_cnt = 5'h00;
			s_nxt.tick_div = 24'h000000;
		end
		s_nxt.running = (s_nxt.run == RUN_PLAY);

		// zone select covers only the zones in the length
		if (ZONE_PRESS) begin
			s_nxt.zone = (s_r.zone >= last_zone) ? 2'h0 : s_r.zone + 2'h1;
		end else if (s_r.zone > last_zone) begin
			s_nxt.zone = 2'h0;
		end

		// pad edits
		if (PAD_PRESS) begin
			if (EDIT_HOLD) begin
				if (PAD_NUM <= ACCENT_TONE) begin
					s_nxt.tone = PAD_NUM;
				end
			end else if (PAD_EDIT_ACTIVE) begin
				s_nxt.pattern[s_r.tone][{s_r.zone, PAD_NUM}] =
					~s_r.pattern[s_r.tone][{s_r.zone, PAD_NUM}];
				if (!FAV_PLAY) begin
					s_nxt.dirty = 1'b1;
				end
			end
		end

		// output routing; no program change path exists
		s_nxt.drive = (s_r.mode == MODE_PROG) || s_r.seq_sel;
		unique case (s_r.mode)
			MODE_PROG: begin
				s_nxt.tx_en = s_r.out_en;
				s_nxt.chan = s_r.prog_chan;
			end
			MODE_COMBI: begin
				s_nxt.tx_en = s_r.seq_sel & ((s_r.route == ROUTE_EXT_OUT) ||
					(s_r.route == ROUTE_EXT2_OUT));
				s_nxt.chan = s_r.part_chan;
			end
			MODE_SONG: begin
				s_nxt.tx_en = s_r.seq_sel & (s_r.route != ROUTE_INT);
				s_nxt.chan = s_r.part_chan;
			end
			default: begin
				s_nxt.tx_en = 1'b0;
				s_nxt.chan = s_r.part_chan;
			end
		endcase

		// apb read decode in setup, answer in access phase
		setup = PSEL & ~PENABLE;
		wr = PSEL & PENABLE & s_r.pready & PWRITE;
		s_nxt.pready = setup;
		s_nxt.pslverr = 1'b0;
		case (PADDR)
			ADDR_CTRL: begin
				rd[CTRL_LEN_LSB +: 6] = s_r.len_m1;
				rd[CTRL_RES_LSB +: 2] = s_r.res;
				rd[CTRL_SPB_LSB +: 2] = s_r.spb;
				rd[CTRL_MODE_LSB +: 2] = s_r.mode;
				rd[CTRL_SRC_LSB +: 2] = s_r.src;
				rd[CTRL_OUT_EN_BIT] = s_r.out_en;
				rd[CTRL_SEQ_SEL_BIT] = s_r.seq_sel;
				rd[CTRL_ROUTE_LSB +: 2] = s_r.route;
			end
			ADDR_CHAN: begin
				rd[CHAN_PROG_LSB +: 4] = s_r.prog_chan;
				rd[CHAN_PART_LSB +: 4] = s_r.part_chan;
			end
			ADDR_TEMPO: rd[23:0] = s_r.tick_period;
			ADDR_STATUS: begin
				rd[5:0] = s_r.pos;
				rd[7:6] = s_r.zone;
				rd[11:8] = s_r.tone;
				rd[13:12] = s_r.run;
				rd[14] = ext_follow;
				rd[STATUS_DIRTY_BIT] = s_r.dirty;
			end
			ADDR_PAT_SEL: rd[3:0] = s_r.pat_sel;
			ADDR_PAT_LO: rd = s_r.pattern[s_r.pat_sel][31:0];
			ADDR_PAT_HI: rd = s_r.pattern[s_r.pat_sel][63:32];
			default: s_nxt.pslverr = setup;
		endcase
		s_nxt.prdata = (setup & ~PWRITE) ? rd : 32'h0000_0000;

		// apb writes at the access edge
		if (wr) begin
			case (PADDR)
				ADDR_CTRL: begin
					s_nxt.len_m1 = PWDATA[CTRL_LEN_LSB +: 6];
					s_nxt.res = PWDATA[CTRL_RES_LSB +: 2];
					s_nxt.spb = PWDATA[CTRL_SPB_LSB +: 2];
					s_nxt.mode = mode_e'(PWDATA[CTRL_MODE_LSB +: 2]);
					s_nxt.src = src_e'(PWDATA[CTRL_SRC_LSB +: 2]);
					s_nxt.out_en = PWDATA[CTRL_OUT_EN_BIT];
					s_nxt.seq_sel = PWDATA[CTRL_SEQ_SEL_BIT];
					s_nxt.route = route_e'(PWDATA[CTRL_ROUTE_LSB +: 2]);
				end
				ADDR_CHAN: begin
					s_nxt.prog_chan = PWDATA[CHAN_PROG_LSB +: 4];
					s_nxt.part_chan = PWDATA[CHAN_PART_LSB +: 4];
				end
				ADDR_TEMPO: begin
					s_nxt.tick_period = (PWDATA[23:0] == 24'h000000) ? 24'h000001 :
						PWDATA[23:0];
				end
				ADDR_STATUS: begin
					// write one clears; a same-cycle edit keeps it set
					if (PWDATA[STATUS_DIRTY_BIT] &&
						!(PAD_PRESS && PAD_EDIT_ACTIVE && !EDIT_HOLD && !FAV_PLAY)) begin
						s_nxt.dirty = 1'b0;
					end
				end
				ADDR_PAT_SEL: begin
					s_nxt.pat_sel = (PWDATA[3:0] > ACCENT_TONE) ? ACCENT_TONE : PWDATA[3:0];
				end
				ADDR_PAT_LO: s_nxt.pattern[s_r.pat_sel][31:0] = PWDATA;
				ADDR_PAT_HI: s_nxt.pattern[s_r.pat_sel][63:32] = PWDATA;
				default: ;
			endcase
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			s_r <= '0;
			s_r.len_m1 <= LEN_M1_RST;
			s_r.res <= RES_RST;
			s_r.prog_chan <= PROG_CHAN_RST;
			s_r.part_chan <= PART_CHAN_RST;
			s_r.tick_period <= TICK_PERIOD_RST;
			s_r.mode <= MODE_PROG;
			s_r.src <= SRC_INT;
			s_r.route <= ROUTE_INT;
			s_r.run <= RUN_STOP;
			s_r.drive <= 1'b1;
			s_r.chan <= PROG_CHAN_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state register
	assign PRDATA = s_r.prdata;
	assign PREADY = s_r.pready;
	assign PSLVERR = s_r.pslverr;
	assign STEP_STROBE = s_r.strobe;
	assign STEP_HITS = s_r.hits;
	assign STEP_ACCENT = s_r.accent;
	assign STEP_POS = s_r.pos;
	assign NOTE_TX_EN = s_r.tx_en;
	assign NOTE_CHANNEL = s_r.chan;
	assign SEQ_DRIVE = s_r.drive;
	assign RUNNING = s_r.running;
	assign ZONE_SEL = s_r.zone;
	assign TONE_SEL = s_r.tone;

endmodule

// ===== include/drum_seq_pkg.sv
package drum_seq_pkg;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CHAN = 8'h04;
	localparam logic [7:0] ADDR_TEMPO = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_PAT_SEL = 8'h10;
	localparam logic [7:0] ADDR_PAT_LO = 8'h14;
	localparam logic [7:0] ADDR_PAT_HI = 8'h18;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CTRL_LEN_LSB = 0;
	localparam int CTRL_RES_LSB = 6;
	localparam int CTRL_SPB_LSB = 8;
	localparam int CTRL_MODE_LSB = 10;
	localparam int CTRL_SRC_LSB = 12;
	localparam int CTRL_OUT_EN_BIT = 14;
	localparam int CTRL_SEQ_SEL_BIT = 15;
	localparam int CTRL_ROUTE_LSB = 16;
	localparam int CHAN_PROG_LSB = 0;
	localparam int CHAN_PART_LSB = 4;
	localparam int STATUS_DIRTY_BIT = 15;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [5:0] LEN_M1_RST = 6'h3f;
	localparam logic [1:0] RES_RST = 2'h2;
	localparam logic [3:0] PROG_CHAN_RST = 4'hf;
	localparam logic [3:0] PART_CHAN_RST = 4'hf;
	localparam logic [23:0] TICK_PERIOD_RST = 24'h065b9a;

	// ****************************************
	// pattern geometry and timing
	// ****************************************
	localparam int NUM_TONES = 13;
	localparam int NUM_INST_TONES = 12;
	localparam logic [3:0] ACCENT_TONE = 4'hc;
	localparam logic [4:0] TICKS_PER_QUARTER = 5'h18;
	localparam int CLK_HZ = 20_000_000;
	localparam int AUTO_TIMEOUT_MS = 300;
	localparam int AUTO_TIMEOUT_CYC = AUTO_TIMEOUT_MS * (CLK_HZ / 1000);

	// ****************************************
	// enumerations
	// ****************************************
	typedef enum logic [1:0] {
		MODE_PROG = 2'b00,
		MODE_COMBI = 2'b01,
		MODE_SONG = 2'b10,
		MODE_SPARE = 2'b11
	} mode_e;

	typedef enum logic [1:0] {
		SRC_INT = 2'b00,
		SRC_CLOCK_A = 2'b01,
		SRC_EXT_USB_CLOCK = 2'b10,
		SRC_AUTO = 2'b11
	} src_e;

	typedef enum logic [1:0] {
		ROUTE_INT = 2'b00,
		ROUTE_EXT_OUT = 2'b01,
		ROUTE_EXT2_OUT = 2'b10,
		ROUTE_BOTH_INT_EXT = 2'b11
	} route_e;

	typedef enum logic [1:0] {
		RUN_STOP = 2'b00,
		RUN_WAIT = 2'b01,
		RUN_PLAY = 2'b10
	} run_e;

endpackage

// ===== verif/drum_seq_checker.sv
`timescale 1ns/100ps
module drum_seq_checker (
	// clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// apb
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// panel
	input wire logic RUN_PRESS,
	input wire logic ZONE_PRESS,
	input wire logic PAD_PRESS,
	input wire logic [3:0] PAD_NUM,
	input wire logic EDIT_HOLD,
	input wire logic REC_COUNT_IN,
	input wire logic REC_START,
	// step stream
	input wire logic STEP_STROBE,
	input wire logic [5:0] STEP_POS,
	input wire logic RUNNING,
	input wire logic [1:0] ZONE_SEL,
	input wire logic [3:0] TONE_SEL
);
	// ****************************************
	// timing relations at the ports
	// ****************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	property p_rdy; PSEL && !PENABLE |=> PREADY; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready after setup");
	property p_one; PREADY |=> !PREADY; endproperty
	a_one: assert property (p_one) else $error("ready held too long");
	property p_err; PSLVERR |-> PREADY; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_rdz; !PREADY |-> PRDATA == 32'h0; endproperty
	a_rdz: assert property (p_rdz) else $error("read data outside access");
	property p_stb; STEP_STROBE |-> $past(RUNNING); endproperty
	a_stb: assert property (p_stb) else $error("step while stopped");
	property p_pos; STEP_STROBE |-> STEP_POS == 6'h00 || STEP_POS == $past(STEP_POS) + 6'h01; endproperty
	a_pos: assert property (p_pos) else $error("step position jumped");
	property p_zone; ZONE_PRESS |=> ZONE_SEL == 2'h0 || ZONE_SEL == $past(ZONE_SEL) + 2'h1; endproperty
	a_zone: assert property (p_zone) else $error("zone did not advance");
	property p_tone; EDIT_HOLD && PAD_PRESS && PAD_NUM <= 4'hc |=> TONE_SEL == $past(PAD_NUM); endproperty
	a_tone: assert property (p_tone) else $error("tone not selected");
	property p_run; RUN_PRESS && RUNNING |=> !RUNNING; endproperty
	a_run: assert property (p_run) else $error("run press did not stop");
	property p_cin; !RUNNING && RUN_PRESS && REC_COUNT_IN && !REC_START |=> !RUNNING; endproperty
	a_cin: assert property (p_cin) else $error("started during count-in");
endmodule

bind drum_step_sequencer drum_seq_checker u_chk (.CLK, .RST_N, .PSEL, .PENABLE, .PRDATA,
	.PREADY, .PSLVERR, .RUN_PRESS, .ZONE_PRESS, .PAD_PRESS, .PAD_NUM, .EDIT_HOLD,
	.REC_COUNT_IN, .REC_START, .STEP_STROBE, .STEP_POS, .RUNNING, .ZONE_SEL, .TONE_SEL);

// ===== verif/midi_partner.sv
`timescale 1ns/100ps
module midi_partner (
	// midi realtime pins, low between messages
	output logic clk_tick,
	output logic start_msg
);
	// idle pins
	initial begin
		clk_tick = 1'b0;
		start_msg = 1'b0;
	end
	// one pulse per timing clock message, own time base
	task automatic send_ticks(input int n);
		repeat (n) begin
			#150 clk_tick = 1'b1;
			#250 clk_tick = 1'b0;
		end
	endtask
	// one pulse per start message
	task automatic send_start();
		#150 start_msg = 1'b1;
		#250 start_msg = 1'b0;
	endtask
endmodule

// ===== verif/drum_step_sequencer_tb.sv
`timescale 1ns/100ps
module drum_step_sequencer_tb;
	import drum_seq_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd, prdata, hist = 32'h0;
	logic [5:0] pr = 6'h00, pos;
	logic [3:0] pad = 4'h0, chan, tone;
	logic [11:0] hits;
	logic [1:0] zone;
	logic hold = 1'b0, pedit = 1'b0, cin = 1'b0, arp = 1'b0, fav = 1'b0, song = 1'b0;
	logic [1:0] sp = 2'b00;
	logic perr, pready, pslverr, stb, acc, tx, drive, running, mt, ms;
	int n_fail = 0, comparisons = 0, n_stb = 0, gap = 0, t_last = 0, cyc = 0, k;
	logic [31:0] ctl [8] = '{32'h0, 32'h4000, 32'h18400, 32'h8400, 32'h38400, 32'h38800,
		32'h28800, 32'h0800};
	logic [1:0] ex [8] = '{2'b10, 2'b11, 2'b11, 2'b10, 2'b10, 2'b11, 2'b11, 2'b00};

	drum_step_sequencer #(.AUTO_TIMEOUT_CYCLES(64)) u_dut (.CLK(clk), .RST_N(rst_n),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .MIDI_CLK_TICK(mt),
		.MIDI_START(ms), .RUN_PRESS(pr[0]), .ZONE_PRESS(pr[1]), .PAD_PRESS(pr[2]),
		.PAD_NUM(pad), .EDIT_HOLD(hold), .PAD_EDIT_ACTIVE(pedit), .FAV_PLAY(fav),
		.ARP_PLAYING(arp), .ARP_STEP(pr[5]), .DRUM_PLAYING(song), .DRUM_STEP(sp[0]),
		.SONG_PLAYING(song), .SONG_BEAT(sp[1]), .SONG_START(pr[3]), .REC_COUNT_IN(cin),
		.REC_START(pr[4]), .STEP_STROBE(stb), .STEP_HITS(hits), .STEP_ACCENT(acc),
		.STEP_POS(pos), .NOTE_TX_EN(tx), .NOTE_CHANNEL(chan), .SEQ_DRIVE(drive),
		.RUNNING(running), .ZONE_SEL(zone), .TONE_SEL(tone));
	midi_partner u_mid (.clk_tick(mt), .start_msg(ms));

	// 50 ns clock
	always #25 clk = ~clk;
	// log of played steps and their spacing
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (stb === 1'b1) begin
			n_stb <= n_stb + 1;
			hist <= {hist[30:0], hits[0]};
			gap <= cyc - t_last;
			t_last <= cyc;
		end
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic press(input logic [5:0] m);
		@(posedge clk);
		pr <= m;
		@(posedge clk);
		pr <= 6'h00;
		@(negedge clk);
	endtask
	// one-cycle drum step / song beat pulse
	task automatic beat(input logic [1:0] m);
		@(posedge clk);
		sp <= m;
		@(posedge clk);
		sp <= 2'b00;
		@(negedge clk);
	endtask
	task automatic wait_stb(input int n);
		repeat (n) begin
			k = n_stb;
			while (n_stb == k) @(posedge clk);
		end
		@(negedge clk);
	endtask
	task automatic print_verdict();
		$display("n_fail=%0d comparisons=%0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		chk(chan, 32'hf);
		chk(tx, 32'h0);
		rdchk(ADDR_CTRL, 32'hbf);
		rdchk(ADDR_CHAN, 32'hff);
		rdchk(8'h1c, 32'h0);
		chk(perr, 32'h1);
	endtask
	task automatic t_loop();
		apb(1'b1, ADDR_TEMPO, 32'h1);
		apb(1'b1, ADDR_PAT_SEL, 32'h0);
		apb(1'b1, ADDR_PAT_LO, 32'h3);
		apb(1'b1, ADDR_CTRL, 32'h82);
		press(6'h01);
		wait_stb(6);
		chk(hist[5:0], 32'h36);
		chk(pos, 32'h0);
	endtask
	task automatic t_rate();
		for (int r = 0; r < 4; r++) begin
			apb(1'b1, ADDR_CTRL, 32'(r << 6) | 32'h2);
			wait_stb(3);
			chk(32'(gap), 32'(24 >> r));
		end
		apb(1'b1, ADDR_CTRL, 32'h182);
		wait_stb(3);
		chk(32'(gap), 32'h3);
	endtask
	task automatic t_ext();
		press(6'h01);
		apb(1'b1, ADDR_CTRL, 32'h1083);
		press(6'h01);
		k = n_stb;
		u_mid.send_ticks(12);
		repeat (8) @(negedge clk);
		chk(32'(n_stb - k), 32'h2);
		chk(pos, 32'h2);
		u_mid.send_start();
		repeat (6) @(negedge clk);
		chk(pos, 32'h0);
		@(posedge clk) arp <= 1'b1;
		press(6'h20);
		repeat (3) @(negedge clk);
		chk(pos, 32'h1);
		@(posedge clk) arp <= 1'b0;
		press(6'h08);
		repeat (2) @(negedge clk);
		chk(pos, 32'h0);
	endtask
	task automatic t_cin();
		press(6'h01);
		chk(running, 32'h0);
		@(posedge clk) cin <= 1'b1;
		press(6'h01);
		chk(running, 32'h0);
		press(6'h10);
		chk(running, 32'h1);
		@(posedge clk) cin <= 1'b0;
		press(6'h01);
		chk(running, 32'h0);
	endtask
	task automatic t_edit();
		apb(1'b1, ADDR_CTRL, 32'h9f);
		@(posedge clk) hold <= 1'b1;
		pad <= 4'hc;
		press(6'h04);
		chk(tone, 32'hc);
		@(posedge clk) pad <= 4'hd;
		press(6'h04);
		chk(tone, 32'hc);
		@(posedge clk) hold <= 1'b0;
		pedit <= 1'b1;
		press(6'h02);
		chk(zone, 32'h1);
		@(posedge clk) pad <= 4'h3;
		press(6'h04);
		@(posedge clk) pedit <= 1'b0;
		press(6'h02);
		chk(zone, 32'h0);
		apb(1'b1, ADDR_PAT_SEL, 32'hc);
		rdchk(ADDR_PAT_LO, 32'h00080000);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd[15:6], 32'h230);
	endtask
	task automatic t_out();
		apb(1'b1, ADDR_CHAN, 32'h52);
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, ADDR_CTRL, ctl[i]);
			repeat (2) @(negedge clk);
			chk({drive, tx}, ex[i]);
		end
		apb(1'b1, ADDR_CTRL, 32'h4000);
		repeat (2) @(negedge clk);
		chk(chan, 32'h2);
		apb(1'b1, ADDR_CTRL, 32'h18400);
		repeat (2) @(negedge clk);
		chk(chan, 32'h5);
	endtask
	task automatic t_sync();
		apb(1'b1, ADDR_TEMPO, 32'h1000);
		apb(1'b1, ADDR_PAT_LO, 32'h2);
		apb(1'b1, ADDR_CTRL, 32'h88bf);
		apb(1'b1, ADDR_STATUS, 32'h8000);
		@(posedge clk) song <= 1'b1;
		press(6'h01);
		beat(2'b01);
		chk(pos, 32'h1);
		chk(hits, 32'h1);
		beat(2'b10);
		chk(pos, 32'h2);
		chk(acc, 32'h1);
		apb(1'b1, ADDR_CTRL, 32'h08bf);
		press(6'h08);
		beat(2'b01);
		chk({hits, acc}, 32'h0);
		@(posedge clk) song <= 1'b0;
		beat(2'b11);
		chk(pos, 32'h1);
		@(posedge clk) fav <= 1'b1;
		pedit <= 1'b1;
		pad <= 4'h3;
		press(6'h04);
		@(posedge clk) fav <= 1'b0;
		pedit <= 1'b0;
		rdchk(ADDR_PAT_LO, 32'ha);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd[15], 32'h0);
		press(6'h01);
	endtask

	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		t_reset();
		t_loop();
		t_rate();
		t_ext();
		t_cin();
		t_edit();
		t_out();
		t_sync();
		print_verdict();
	end
	// watchdog
	initial begin
		repeat (8000) @(posedge clk);
		n_fail++;
		print_verdict();
	end
endmodule
